// ---- usf_defs.svh ----
// constants for the serial status flag block: offsets, reset values, timing
// assumes a 100 MHz aclk and a 16x oversampled bit clock
`ifndef USF_DEFS_SVH
`define USF_DEFS_SVH

`define USF_OFF_STATUS     4'h0
`define USF_OFF_DATA       4'h4
`define USF_OFF_CTRL       4'h8
`define USF_OFF_BAUD       4'hc

`define USF_RESP_OKAY      2'h0
`define USF_RESP_SLVERR    2'h2

`define USF_CTRL_RESET     8'h00
`define USF_BAUD_RESET     16'h0036
`define USF_FLAGS_RESET    8'hc0

`define USF_TICKS_PER_BIT  16
`define USF_CHAR_BITS_8    10
`define USF_CHAR_BITS_9    11
`define USF_START_FIRST    4'h4
`define USF_START_LAST     4'ha
`define USF_START_MAJ      3'h3
`define USF_BIT_SMP_FIRST  4'h7
`define USF_BIT_SMP_LAST   4'h9
`define USF_BIT_DECIDE     4'ha
`define USF_PH_LAST        4'hf

`endif

// ---- usf_pkg.sv ----
// types for the serial status flag block
// used together with usf_defs.svh
package usf_pkg;

    typedef struct packed {
        logic tx_buffer_empty;
        logic transmit_done;
        logic rx_buffer_full;
        logic idle_flag;
        logic overrun_flag;
        logic noise_flag;
        logic framing_error_flag;
        logic parity_error_flag;
    } usf_flags_s;

    typedef struct packed {
        logic tx_empty_irq_enable;
        logic rsvd;
        logic nine_bit;
        logic queue_break;
        logic tx_on;
        logic idle_count_after_stop;
        logic parity_on;
        logic parity_odd_select;
    } usf_ctrl_s;

    typedef enum logic [1:0] {
        USF_RX_IDLE  = 2'b00,
        USF_RX_START = 2'b01,
        USF_RX_DATA  = 2'b10,
        USF_RX_STOP  = 2'b11
    } usf_rx_state_e;

    typedef enum logic [0:0] {
        USF_TX_IDLE = 1'b0,
        USF_TX_SEND = 1'b1
    } usf_tx_state_e;

endpackage

// ---- usf_status_flags.sv ----
// serial port core with its status flag register, reached over AXI4-Lite
// assumes rxd synchronous to aclk; one write and one read in flight at most
//
// What this block does
// - status register is read-only; writes change nothing, flags clear by sequences only
// - tx buffer empty sets at reset and when buffer moves to shifter
// - status read seeing tx empty, then data write, clears tx empty
// - transmit done sets at reset and when buffer empty and nothing sending
// - armed transmit done clears on data write, tx enable rise, or break write
// - rx full sets on character load; armed status read then data read clears
// - idle sets after line high for 10 bit times, 11 with nine bits
// - idle-type 0 counts idle time from right after the start bit
// - idle-type 1 counts idle time only after the stop bit
// - armed status read then data read clears idle
// - idle sets once, then waits for a new received character
// - overrun sets when new character finds buffer unread; new character discarded
// - armed status read then data read clears overrun
// - seven start samples, three per bit; disagreement sets noise with rx full
// - status read then data read clears noise
// - low stop bit sets framing error with rx full
// - armed status read then data read clears framing error
// - parity mismatch sets parity error with rx full when parity on
// - status read then data read clears parity error
// - parity even for select 0, odd for 1, counting the parity bit
// - interrupt request while tx empty is set and its enable is on
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "usf_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module usf_status_flags
    import usf_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        rxd,
    output logic             txd,
    output logic             irq_tx_empty
);

    usf_flags_s    flags;
    usf_flags_s    arm;
    usf_ctrl_s     ctrl;
    logic [15:0]   baud_div;
    logic [15:0]   baud_cnt;
    logic          tick;
    logic          aw_hold;
    logic          w_hold;
    logic [3:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          wr_go;
    logic          rd_go;
    logic          wr_lane0;
    logic          data_wr;
    logic          ctrl_wr;
    logic          status_rd;
    logic          data_rd;
    usf_ctrl_s     wr_ctrl;
    logic          pre_start;
    logic          brk_wr1;
    usf_rx_state_e rx_state;
    logic [3:0]    rx_ph;
    logic [3:0]    rx_bit;
    logic [2:0]    rx_ones;
    logic [2:0]    rx_smp;
    logic [8:0]    rx_sh;
    logic          rx_noise;
    logic          rx_done;
    logic          rx_fe;
    logic          rx_nf;
    logic [8:0]    rx_data;
    logic          smp_maj;
    logic          smp_dis;
    logic [8:0]    rx_word;
    logic          rx_par_err;
    logic [7:0]    idle_cnt;
    logic [7:0]    idle_thr;
    logic          idle_hit;
    logic          idle_armed;
    usf_tx_state_e tx_state;
    logic [3:0]    tx_ph;
    logic [3:0]    tx_cnt;
    logic [10:0]   tx_sh;
    logic [8:0]    tx_buf;
    logic          buf_valid;
    logic          pre_pend;
    logic          tx_go;
    logic          ld_pre;
    logic          ld_dat;
    logic          ld_brk;
    logic [8:0]    tx_word;
    logic [10:0]   tx_frame;
    logic [3:0]    tx_len;
    logic          tc_set;
    logic [5:0]    rx_clr;

    // bus slave handshakes
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go         = aw_hold & w_hold & ~s_axi_bvalid;
    assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
    assign wr_lane0      = wr_go & w_strb[0];
    assign data_wr       = wr_lane0 & (aw_addr == `USF_OFF_DATA);
    assign ctrl_wr       = wr_lane0 & (aw_addr == `USF_OFF_CTRL);
    assign status_rd     = rd_go & ({s_axi_araddr[3:2], 2'b00} == `USF_OFF_STATUS);
    assign data_rd       = rd_go & ({s_axi_araddr[3:2], 2'b00} == `USF_OFF_DATA);
    assign wr_ctrl       = usf_ctrl_s'(w_data[7:0]);
    assign pre_start     = ctrl_wr & wr_ctrl.tx_on & ~ctrl.tx_on;
    assign brk_wr1       = ctrl_wr & wr_ctrl.queue_break;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0;
            w_strb  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold <= 1'b1;
                aw_addr <= {s_axi_awaddr[3:2], 2'b00};
            end
            else if (wr_go)
                aw_hold <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_hold <= 1'b0;
        end
    end

    // write response; status writes answer okay and do nothing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `USF_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                `USF_OFF_STATUS, `USF_OFF_DATA,
                `USF_OFF_CTRL, `USF_OFF_BAUD: s_axi_bresp <= `USF_RESP_OKAY;
                default:                      s_axi_bresp <= `USF_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read data, taken at the address edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `USF_RESP_OKAY;
        end
        else if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `USF_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                `USF_OFF_STATUS: s_axi_rdata <= {24'h0, flags};
                `USF_OFF_DATA:   s_axi_rdata <= {23'h0, rx_data};
                `USF_OFF_CTRL:   s_axi_rdata <= {24'h0, ctrl};
                `USF_OFF_BAUD:   s_axi_rdata <= {16'h0, baud_div};
                default:
                begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `USF_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // software registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl     <= usf_ctrl_s'(`USF_CTRL_RESET);
            baud_div <= `USF_BAUD_RESET;
        end
        else
        begin
            if (ctrl_wr)
            begin
                ctrl      <= wr_ctrl;
                ctrl.rsvd <= 1'b0;
            end
            if (wr_go && (aw_addr == `USF_OFF_BAUD) && (&w_strb[1:0]))
                baud_div <= w_data[15:0];
        end
    end

    // 16x bit clock
    assign tick = (baud_cnt >= baud_div);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            baud_cnt <= 16'h0;
        else if (tick)
            baud_cnt <= 16'h0;
        else
            baud_cnt <= baud_cnt + 16'h1;
    end

    // receiver
    assign smp_maj    = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2]) | (rx_smp[1] & rx_smp[2]);
    assign smp_dis    = (|rx_smp) & ~(&rx_smp);
    assign rx_word    = ctrl.nine_bit ? rx_sh : {1'b0, rx_sh[8:1]};
    assign rx_par_err = ctrl.parity_on & ((^rx_word) ^ ctrl.parity_odd_select);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_state <= USF_RX_IDLE;
            rx_ph    <= 4'h0;
            rx_bit   <= 4'h0;
            rx_ones  <= 3'h0;
            rx_smp   <= 3'h0;
            rx_sh    <= 9'h0;
            rx_noise <= 1'b0;
            rx_done  <= 1'b0;
            rx_fe    <= 1'b0;
            rx_nf    <= 1'b0;
        end
        else
        begin
            rx_done <= 1'b0;
            if (tick)
            begin
                case (rx_state)
                    USF_RX_IDLE:
                    begin
                        if (!rxd)
                        begin
                            rx_state <= USF_RX_START;
                            rx_ph    <= 4'h1;
                            rx_ones  <= 3'h0;
                        end
                    end
                    USF_RX_START:
                    begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph >= `USF_START_FIRST && rx_ph <= `USF_START_LAST)
                            rx_ones <= rx_ones + {2'b00, rxd};
                        if (rx_ph == `USF_PH_LAST)
                        begin
                            if (rx_ones > `USF_START_MAJ)
                                rx_state <= USF_RX_IDLE;
                            else
                            begin
                                rx_state <= USF_RX_DATA;
                                rx_bit   <= 4'h0;
                                rx_noise <= (rx_ones != 3'h0);
                            end
                        end
                    end
                    USF_RX_DATA, USF_RX_STOP:
                    begin
                        rx_ph <= rx_ph + 4'h1;
                        if (rx_ph >= `USF_BIT_SMP_FIRST && rx_ph <= `USF_BIT_SMP_LAST)
                            rx_smp <= {rx_smp[1:0], rxd};
                        if (rx_ph == `USF_BIT_DECIDE && rx_state == USF_RX_DATA)
                        begin
                            rx_sh    <= {smp_maj, rx_sh[8:1]};
                            rx_noise <= rx_noise | smp_dis;
                        end
                        if (rx_ph == `USF_BIT_DECIDE && rx_state == USF_RX_STOP)
                        begin
                            rx_done <= 1'b1;
                            rx_fe   <= ~smp_maj;
                            rx_nf   <= rx_noise | smp_dis;
                        end
                        if (rx_ph == `USF_PH_LAST)
                        begin
                            if (rx_state == USF_RX_STOP)
                                rx_state <= USF_RX_IDLE;
                            else if (rx_bit == (ctrl.nine_bit ? 4'h8 : 4'h7))
                                rx_state <= USF_RX_STOP;
                            else
                                rx_bit <= rx_bit + 4'h1;
                        end
                    end
                    default: rx_state <= USF_RX_IDLE;
                endcase
            end
        end
    end

    // idle line detection
    assign idle_thr = ctrl.nine_bit ? 8'(`USF_CHAR_BITS_9 * `USF_TICKS_PER_BIT)
                                    : 8'(`USF_CHAR_BITS_8 * `USF_TICKS_PER_BIT);
    assign idle_hit = tick & rxd & (idle_cnt == idle_thr - 8'h1);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            idle_cnt <= 8'h0;
        else if (tick)
        begin
            if (!rxd || rx_state == USF_RX_START)
                idle_cnt <= 8'h0;
            else if (ctrl.idle_count_after_stop && rx_state != USF_RX_IDLE)
                idle_cnt <= 8'h0;
            else if (idle_cnt != idle_thr)
                idle_cnt <= idle_cnt + 8'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            idle_armed <= 1'b0;
        else if (rx_done && !flags.rx_buffer_full)
            idle_armed <= 1'b1;
        else if (idle_hit)
            idle_armed <= 1'b0;
    end

    // receive data register; an overrun keeps the old character
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rx_data <= 9'h0;
        else if (rx_done && !flags.rx_buffer_full)
            rx_data <= rx_word;
    end

    // transmitter
    assign tx_go    = (tx_state == USF_TX_IDLE) & ctrl.tx_on;
    assign ld_pre   = tx_go & pre_pend;
    assign ld_dat   = tx_go & ~pre_pend & buf_valid;
    assign ld_brk   = tx_go & ~pre_pend & ~buf_valid & ctrl.queue_break;
    assign tx_len   = ctrl.nine_bit ? 4'(`USF_CHAR_BITS_9) : 4'(`USF_CHAR_BITS_8);
    assign tx_word  = ctrl.nine_bit ? {tx_buf[8] ^ (ctrl.parity_on & (^tx_buf ^ ctrl.parity_odd_select)),
                                       tx_buf[7:0]}
                                    : {1'b0, tx_buf[7] ^ (ctrl.parity_on
                                       & (^tx_buf[7:0] ^ ctrl.parity_odd_select)), tx_buf[6:0]};
    assign tx_frame = ctrl.nine_bit ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_state <= USF_TX_IDLE;
            tx_ph    <= 4'h0;
            tx_cnt   <= 4'h0;
            tx_sh    <= 11'h7ff;
            txd      <= 1'b1;
        end
        else
        begin
            txd <= (tx_state == USF_TX_SEND) ? tx_sh[0] : 1'b1;
            case (tx_state)
                USF_TX_IDLE:
                begin
                    if (ld_pre || ld_dat || ld_brk)
                    begin
                        tx_state <= USF_TX_SEND;
                        tx_ph    <= 4'h0;
                        tx_cnt   <= 4'h0;
                        tx_sh    <= ld_pre ? 11'h7ff : (ld_dat ? tx_frame : 11'h000);
                    end
                end
                USF_TX_SEND:
                begin
                    if (tick)
                    begin
                        tx_ph <= tx_ph + 4'h1;
                        if (tx_ph == `USF_PH_LAST)
                        begin
                            tx_sh <= {1'b1, tx_sh[10:1]};
                            if (tx_cnt == tx_len - 4'h1)
                                tx_state <= USF_TX_IDLE;
                            else
                                tx_cnt <= tx_cnt + 4'h1;
                        end
                    end
                end
                default: tx_state <= USF_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_buf    <= 9'h0;
            buf_valid <= 1'b0;
            pre_pend  <= 1'b0;
        end
        else
        begin
            if (data_wr)
                tx_buf <= {w_strb[1] & w_data[8], w_data[7:0]};
            buf_valid <= data_wr | (buf_valid & ~ld_dat);
            pre_pend  <= pre_start | (pre_pend & ~ld_pre);
        end
    end

    // status flags: set wins over clear, except transmit done, where a data write, tx enable rise or break write wins
    assign tc_set = flags.tx_buffer_empty & (tx_state == USF_TX_IDLE) & ~pre_pend
                    & ~buf_valid & ~(ctrl.queue_break & ctrl.tx_on)
                    & ~pre_start & ~brk_wr1 & ~data_wr;
    assign rx_clr = data_rd ? arm[5:0] : 6'h00;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags <= usf_flags_s'(`USF_FLAGS_RESET);
        else
        begin
            flags.tx_buffer_empty <= ld_dat
                | (flags.tx_buffer_empty & ~(data_wr & arm.tx_buffer_empty));
            flags.transmit_done <= tc_set
                | (flags.transmit_done & ~(arm.transmit_done
                   & (data_wr | pre_start | brk_wr1)));
            flags.rx_buffer_full <= (rx_done & ~flags.rx_buffer_full)
                | (flags.rx_buffer_full & ~rx_clr[5]);
            flags.idle_flag <= (idle_hit & idle_armed)
                | (flags.idle_flag & ~rx_clr[4]);
            flags.overrun_flag <= (rx_done & flags.rx_buffer_full)
                | (flags.overrun_flag & ~rx_clr[3]);
            flags.noise_flag <= (rx_done & ~flags.rx_buffer_full & rx_nf)
                | (flags.noise_flag & ~rx_clr[2]);
            flags.framing_error_flag <= (rx_done & ~flags.rx_buffer_full & rx_fe)
                | (flags.framing_error_flag & ~rx_clr[1]);
            flags.parity_error_flag <= (rx_done & ~flags.rx_buffer_full & rx_par_err)
                | (flags.parity_error_flag & ~rx_clr[0]);
        end
    end

    // arming snapshot taken at each status read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            arm <= usf_flags_s'(8'h00);
        else if (status_rd)
            arm <= flags;
        else
        begin
            arm[5:0] <= arm[5:0] & ~rx_clr;
            if (data_wr)
                arm.tx_buffer_empty <= 1'b0;
            if (data_wr || pre_start || brk_wr1)
                arm.transmit_done <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_tx_empty <= 1'b0;
        else
            irq_tx_empty <= flags.tx_buffer_empty & ctrl.tx_empty_irq_enable;
    end

endmodule

`default_nettype wire

// ---- usf_status_flags_properties.sv ----
// bus and line assertions for the serial status flag block
// bound to usf_status_flags; single clock aclk, reset aresetn
`timescale 1ns/10ps
`default_nettype none
module usf_status_flags_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        txd
);
    default clocking dclk @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence aw_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence r_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (aw_w_take |-> ##2 s_axi_bvalid)
        else $error("write answer not on time");
    write_block_a: assert property (aw_w_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels not blocked");
    write_retire_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not retired");
    read_answer_a: assert property (r_take |=> s_axi_rvalid)
        else $error("read answer not on time");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    read_okay_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0)
        else $error("read response not okay");
    bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    status_width_a: assert property (
        r_take ##0 s_axi_araddr[3:2] == 2'h0 |=> s_axi_rdata[31:8] == 24'h0)
        else $error("status read upper bits set");
    reset_idle_a: assert property (
        $rose(aresetn) |-> txd && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not idle after reset");
endmodule
bind usf_status_flags usf_status_flags_properties chk (.*);
`default_nettype wire

// ---- usf_serial_peer.sv ----
// remote serial station: drives the receive line, listens on txd
// assumes one 16x tick per aclk cycle (baud divisor 0)
`timescale 1ns/10ps
`default_nettype none
module usf_serial_peer (
    input  wire logic aclk,
    input  wire logic txd,
    output logic      rxd
);
    localparam int BIT = 16;
    initial rxd = 1'h1;
    // start, n data lsb first, stop; nz flips one sample of data bit 1
    task automatic send(input logic [8:0] d, input int n, input logic stp, input logic nz);
        logic v;
        for (int i = 0; i < n + 2; i++)
        begin
            v = (i == 0) ? 1'h0 : (i <= n) ? d[i-1] : stp;
            for (int j = 0; j < BIT; j++)
            begin
                @(posedge aclk);
                rxd <= (nz && i == 2 && j == 8) ? ~v : v;
            end
        end
        @(posedge aclk);
        rxd <= 1'h1;
    endtask
    task automatic recv(output logic [7:0] d);
        @(negedge txd);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge aclk);
            d[i] = txd;
        end
    endtask
endmodule
`default_nettype wire

// ---- tb_uart_status_flags.sv ----
// self-checking bench for the serial status flag register
// drives AXI4-Lite; peer model sits on txd/rxd
`timescale 1ns/10ps
`default_nettype none
module tb_uart_status_flags;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [8:0] d;
        logic       stp;
        logic       nz;
        logic [7:0] st;
    } usf_row_s;
    logic        aclk, rxd, txd, irq_tx_empty, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  b;
    int          bad_count, checks_done, cyc;
    usf_row_s    rows [7] = '{
        {8'h00, 9'h055, 1'h1, 1'h0, 8'he0},
        {8'h00, 9'h055, 1'h0, 1'h0, 8'he2},
        {8'h02, 9'h001, 1'h1, 1'h0, 8'he1},
        {8'h03, 9'h001, 1'h1, 1'h0, 8'he0},
        {8'h03, 9'h003, 1'h1, 1'h0, 8'he1},
        {8'h00, 9'h055, 1'h1, 1'h1, 8'he4},
        {8'h20, 9'h1aa, 1'h1, 1'h0, 8'he0}};
    usf_status_flags DUT (.*);
    usf_serial_peer p (.*);
    initial
    begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask
    task automatic rc(input logic [3:0] a, input string n, input logic [31:0] e);
        rd(a, v);
        chk(n, e, v);
    endtask
    task automatic settle;
        repeat (200) @(posedge aclk);
        rc(4'h0, "idle set", 32'hd0);
        rd(4'h4, v);
        rc(4'h0, "idle clear", 32'hc0);
    endtask
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            end_sim();
        end
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        rc(4'h0, "reset status", 32'hc0);
        wr(4'hc, 32'h0);
        wr(4'h0, 32'h3f);
        rc(4'h0, "status write", 32'hc0);
        foreach (rows[i])
        begin
            wr(4'h8, {24'h0, rows[i].ctrl});
            p.send(rows[i].d, rows[i].ctrl[5] ? 9 : 8, rows[i].stp, rows[i].nz);
            rc(4'h0, "rx status", {24'h0, rows[i].st});
            rc(4'h4, "rx data", {23'h0, rows[i].d});
            rc(4'h0, "rx clear", 32'hc0);
            settle();
        end
        wr(4'h8, 32'h0);
        p.send(9'h011, 8, 1'h1, 1'h0);
        p.send(9'h022, 8, 1'h1, 1'h0);
        rc(4'h0, "overrun", 32'he8);
        rc(4'h4, "kept char", 32'h11);
        rc(4'h0, "overrun clear", 32'hc0);
        settle();
        p.send(9'h0ff, 8, 1'h1, 1'h0);
        repeat (30) @(posedge aclk);
        rc(4'h0, "idle early", 32'hf0);
        rd(4'h4, v);
        repeat (400) @(posedge aclk);
        rc(4'h0, "idle once", 32'hc0);
        wr(4'h8, 32'h4);
        p.send(9'h0ff, 8, 1'h1, 1'h0);
        repeat (30) @(posedge aclk);
        rc(4'h0, "idle late", 32'he0);
        rd(4'h4, v);
        settle();
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rc(4'h0, "second reset", 32'hc0);
        wr(4'hc, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            rc(4'h0, "tx idle", 32'hc0);
            fork
                if (k == 1) p.recv(b);
                begin
                    case (k)
                        0: wr(4'h8, 32'h8);
                        1: wr(4'h4, 32'ha5);
                        default: wr(4'h8, 32'h18);
                    endcase
                    rc(4'h0, "tx busy", 32'h80);
                    if (k == 1) wr(4'h4, 32'h5a);
                    if (k == 1) rc(4'h0, "tx full", 32'h0);
                end
            join
            if (k == 1) chk("tx char", 32'ha5, {24'h0, b});
            wr(4'h8, 32'h8);
            repeat (400) @(posedge aclk);
        end
        wr(4'h8, 32'h88);
        repeat (2) @(posedge aclk);
        chk("irq", 32'h1, {31'h0, irq_tx_empty});
        end_sim();
    end
endmodule
`default_nettype wire
